/* File: verilog/pmr_defs.vh */
// register offsets, field positions and reset values of the master address and enable bank
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH
`define PMR_OFF_IRQ_ENABLE    4'h0
`define PMR_OFF_LOCAL_ADDR    4'h4
`define PMR_OFF_PCI_ADDR      4'h8
`define PMR_OFF_IRQ_STATUS    4'hc
`define PMR_IEN_WIDTH         6
`define PMR_IEN_RESET         6'h08
`define PMR_BIT_WAKE_FALL     5
`define PMR_BIT_WAKE_RISE     4
`define PMR_BIT_HOST_REQ      3
`define PMR_BIT_MASTER_ABORT  2
`define PMR_BIT_TARGET_ABORT  1
`define PMR_BIT_POWER_STATE   0
`define PMR_BIT_STEP_HOLD     1
`define PMR_WRAP_BITS         24
`define PMR_RESP_OKAY         2'b00
`define PMR_RESP_SLVERR       2'b10
`endif

/* File: verilog/pmr_addr_step.v */
// next local word address for one transfer step, wrapping inside the 16m-byte window
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defs.vh"
module pmr_addr_step
(
   input  wire [29:0] word_addr,
   input  wire        step_hold,
   output wire [29:0] next_addr
);
   // 24 byte-address bits are 22 word-address bits
   localparam integer LOW_W = `PMR_WRAP_BITS - 2;
   wire [LOW_W-1:0] low_inc;
   assign low_inc   = word_addr[LOW_W-1:0] + {{(LOW_W-1){1'b0}}, 1'b1};
   // carry out of the low field is dropped on purpose
   assign next_addr = step_hold ? word_addr
                                : {word_addr[29:LOW_W], low_inc};
endmodule
`default_nettype wire

/* File: verilog/pmr_regs.v */
// master address registers and low interrupt enables behind an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defs.vh"
module pmr_regs
#(
   parameter HAS_STEP_HOLD = 1
)
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        warm_resetn,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        power_wakeup_pin,
   input  wire        host_request_evt,
   input  wire        master_abort_evt,
   input  wire        target_abort_evt,
   input  wire        power_state_evt,
   input  wire        xfer_step,
   output wire [29:0] local_word_addr,
   output wire        local_step_hold,
   output wire [29:0] pci_word_addr,
   output wire        irq
);
   localparam IW = `PMR_IEN_WIDTH;

   reg        awready_reg;
   reg        wready_reg;
   reg        bvalid_reg;
   reg [1:0]  bresp_reg;
   reg        arready_reg;
   reg        rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0]  rresp_reg;
   reg [3:0]  awaddr_reg;
   reg        aw_have_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   reg        w_have_reg;
   reg [IW-1:0] ien_reg;
   reg [IW-1:0] status_reg;
   reg [29:0] laddr_reg;
   reg        lhold_reg;
   reg [29:0] paddr_reg;
   reg        irq_reg;
   reg        wake_s1_reg;
   reg        wake_s2_reg;
   reg        wake_s3_reg;

   wire        soft_reset;
   wire        aw_fire;
   wire        w_fire;
   wire        do_write;
   wire [3:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire        ar_fire;
   wire        status_rd;
   wire [IW-1:0] events;
   wire [29:0] laddr_step;
   reg  [31:0] rd_word;
   reg         rd_hit;
   reg  [31:0] cur_word;
   wire [31:0] merged;

   // hardware and warm reset clear the same state, apart from the wakeup synchroniser, which only aresetn clears
   assign soft_reset = !aresetn || !warm_resetn;

   assign aw_fire  = s_axi_awvalid && awready_reg;
   assign w_fire   = s_axi_wvalid && wready_reg;
   assign wr_addr  = aw_have_reg ? awaddr_reg : s_axi_awaddr;
   assign wr_data  = w_have_reg ? wdata_reg : s_axi_wdata;
   assign wr_strb  = w_have_reg ? wstrb_reg : s_axi_wstrb;
   assign do_write = (aw_have_reg || aw_fire) && (w_have_reg || w_fire) && !bvalid_reg;
   assign ar_fire  = s_axi_arvalid && arready_reg;
   assign status_rd = ar_fire && (s_axi_araddr == `PMR_OFF_IRQ_STATUS);

   // wakeup pin is asynchronous; s1 feeds only s2
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_s1_reg <= 1'b0;
         wake_s2_reg <= 1'b0;
         wake_s3_reg <= 1'b0;
      end
      else
      begin
         wake_s1_reg <= power_wakeup_pin;
         wake_s2_reg <= wake_s1_reg;
         wake_s3_reg <= wake_s2_reg;
      end
   end

   assign events[`PMR_BIT_WAKE_FALL]    = wake_s3_reg && !wake_s2_reg;
   assign events[`PMR_BIT_WAKE_RISE]    = !wake_s3_reg && wake_s2_reg;
   assign events[`PMR_BIT_HOST_REQ]     = host_request_evt;
   assign events[`PMR_BIT_MASTER_ABORT] = master_abort_evt;
   assign events[`PMR_BIT_TARGET_ABORT] = target_abort_evt;
   assign events[`PMR_BIT_POWER_STATE]  = power_state_evt;

   // current value of the addressed register, the base for a partial write
   always @*
   begin
      case (wr_addr)
         `PMR_OFF_IRQ_ENABLE: cur_word = {{(32-IW){1'b0}}, ien_reg};
         `PMR_OFF_LOCAL_ADDR: cur_word = {laddr_reg, lhold_reg, 1'b0};
         `PMR_OFF_PCI_ADDR:   cur_word = {paddr_reg, 2'b00};
         default:             cur_word = 32'h0000_0000;
      endcase
   end

   // byte-lane merge: lanes without a strobe keep the stored value
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_lane
         assign merged[8*gi+7:8*gi] = wr_strb[gi] ? wr_data[8*gi+7:8*gi]
                                                  : cur_word[8*gi+7:8*gi];
      end
   endgenerate

   pmr_addr_step u_step
   (
      .word_addr (laddr_reg),
      .step_hold (lhold_reg),
      .next_addr (laddr_step)
   );

   // write address channel: held until the data half arrives
   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         awready_reg <= 1'b1;
         aw_have_reg <= 1'b0;
         awaddr_reg  <= 4'h0;
      end
      else if (do_write)
      begin
         aw_have_reg <= 1'b0;
         awready_reg <= 1'b0;
      end
      else if (aw_fire)
      begin
         aw_have_reg <= 1'b1;
         awaddr_reg  <= s_axi_awaddr;
         awready_reg <= 1'b0;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
         awready_reg <= 1'b1;
      end
   end

   // write data channel: held until the address half arrives
   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         wready_reg  <= 1'b1;
         w_have_reg  <= 1'b0;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end
      else if (do_write)
      begin
         w_have_reg  <= 1'b0;
         wready_reg  <= 1'b0;
      end
      else if (w_fire)
      begin
         w_have_reg  <= 1'b1;
         wdata_reg   <= s_axi_wdata;
         wstrb_reg   <= s_axi_wstrb;
         wready_reg  <= 1'b0;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
         wready_reg  <= 1'b1;
      end
   end

   // write response; all mapped offsets are word aligned, so low bits mark a miss
   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `PMR_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg  <= 1'b1;
         bresp_reg   <= (wr_addr[1:0] == 2'b00) ? `PMR_RESP_OKAY : `PMR_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
         bvalid_reg  <= 1'b0;
      end
   end

   // interrupt enables
   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         ien_reg     <= `PMR_IEN_RESET;
      end
      else if (do_write && (wr_addr == `PMR_OFF_IRQ_ENABLE))
      begin
         ien_reg     <= merged[IW-1:0];
      end
   end

   // local address: a bus write in the same cycle beats a transfer step
   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         laddr_reg   <= 30'h0000_0000;
         lhold_reg   <= 1'b0;
      end
      else if (do_write && (wr_addr == `PMR_OFF_LOCAL_ADDR))
      begin
         // bit 0 is dropped here
         laddr_reg   <= merged[31:2];
         lhold_reg   <= (HAS_STEP_HOLD != 0) ? merged[`PMR_BIT_STEP_HOLD] : 1'b0;
      end
      else if (xfer_step)
      begin
         laddr_reg   <= laddr_step;
      end
   end

   // pci side address
   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         paddr_reg   <= 30'h0000_0000;
      end
      else if (do_write && (wr_addr == `PMR_OFF_PCI_ADDR))
      begin
         paddr_reg   <= merged[31:2];
      end
   end

   // read data mux
   always @*
   begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         `PMR_OFF_IRQ_ENABLE: rd_word = {{(32-IW){1'b0}}, ien_reg};
         `PMR_OFF_LOCAL_ADDR: rd_word = {laddr_reg, lhold_reg, 1'b0};
         `PMR_OFF_PCI_ADDR:   rd_word = {paddr_reg, 2'b00};
         `PMR_OFF_IRQ_STATUS: rd_word = {{(32-IW){1'b0}}, status_reg};
         default:             rd_hit  = 1'b0;
      endcase
   end

   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= `PMR_RESP_OKAY;
      end
      else
      begin
         if (ar_fire)
         begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_word;
            rresp_reg   <= rd_hit ? `PMR_RESP_OKAY : `PMR_RESP_SLVERR;
         end
         else if (rvalid_reg && s_axi_rready)
         begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // sticky status: read clears, a new event in the same cycle survives
   always @(posedge aclk)
   begin
      if (soft_reset)
      begin
         status_reg <= {IW{1'b0}};
         irq_reg    <= 1'b0;
      end
      else
      begin
         // enable does not gate capture, so masking keeps the flag
         status_reg <= (status_rd ? {IW{1'b0}} : status_reg) | events;
         irq_reg    <= |(status_reg & ien_reg);
      end
   end

   assign s_axi_awready   = awready_reg;
   assign s_axi_wready    = wready_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_arready   = arready_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
   assign local_word_addr = laddr_reg;
   assign local_step_hold = lhold_reg;
   assign pci_word_addr   = paddr_reg;
   assign irq             = irq_reg;
endmodule
`default_nettype wire

/* File: sim/pmr_regs_properties.sv */
// concurrent checks on the ports of the master address and enable bank
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_properties
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        warm_resetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        xfer_step,
   input wire logic [29:0] local_word_addr,
   input wire logic        local_step_hold,
   input wire logic [29:0] pci_word_addr,
   input wire logic        irq
);
   logic quiet;
   // no write can land at this edge, so address state may only move by stepping
   assign quiet = !s_axi_awvalid && !s_axi_wvalid && warm_resetn;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_step_hold: assert property (
      local_step_hold && xfer_step && quiet |=> $stable(local_word_addr))
      else $error("local address moved while held");
   a_step_wrap: assert property (
      !local_step_hold && xfer_step && quiet
      |=> local_word_addr[21:0] == $past(local_word_addr[21:0]) + 22'h1)
      else $error("local address did not advance one word");
   a_step_upper: assert property (
      xfer_step && quiet |=> local_word_addr[29:22] == $past(local_word_addr[29:22]))
      else $error("step carried into upper bits");
   a_local_kept: assert property (
      quiet && !xfer_step |=> $stable(local_word_addr))
      else $error("local address changed with no cause");
   a_mode_kept: assert property (
      quiet |=> $stable(local_step_hold))
      else $error("step mode changed with no write");
   a_pci_kept: assert property (
      quiet |=> $stable(pci_word_addr))
      else $error("pci address changed with no write");
   a_warm_clear: assert property (
      !warm_resetn |=> local_word_addr == 30'h0 && pci_word_addr == 30'h0 && !local_step_hold)
      else $error("warm reset left address state");
   a_warm_irq: assert property (
      !warm_resetn |=> !irq)
      else $error("irq high after warm reset");
endmodule
bind pmr_regs pmr_regs_properties u_prop (.aclk(aclk), .aresetn(aresetn),
   .warm_resetn(warm_resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
   .xfer_step(xfer_step), .local_word_addr(local_word_addr),
   .local_step_hold(local_step_hold), .pci_word_addr(pci_word_addr), .irq(irq));
`default_nettype wire

/* File: sim/pmr_far_model.sv */
// far-side stand-in: pci event sources, wakeup pin and transfer engine steps
`timescale 1ns/100ps
`default_nettype none
module pmr_far_model
(
   input  wire logic       aclk,
   input  wire logic [6:0] kick,
   output var  logic [3:0] evt  = 4'h0,
   output var  logic       pin  = 1'b0,
   output var  logic       step = 1'b0
);
   always @(posedge aclk)
   begin
      evt <= kick[3:0];
      step <= kick[6];
      // the pin is a level: each request flips it, so a rise comes before a fall
      pin <= pin ^ (kick[4] | kick[5]);
   end
endmodule
`default_nettype wire

/* File: sim/pmr_regs_tb_top.sv */
// self-checking bench for the master address and enable register bank
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_tb_top;
   logic        aclk = 0, aresetn = 0, warm_resetn = 1;
   logic [3:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [6:0]  kick = 0;
   logic [1:0]  bresp_got = 0, rresp_got = 0;
   wire         awready, wready, bvalid, arready, rvalid, irq, hold, step, pin;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [29:0] laddr, paddr;
   wire  [3:0]  evt;
   int          err_count = 0, n_checks = 0, cyc = 0;
   logic [67:0] rows [6] = '{{4'h0, 32'hffffffff, 32'h3f}, {4'h0, 32'h0, 32'h0},
      {4'h4, 32'hffffffff, 32'hfffffffe}, {4'h4, 32'h12345679, 32'h12345678},
      {4'h8, 32'hffffffff, 32'hfffffffc}, {4'h8, 32'ha5a5a5a7, 32'ha5a5a5a4}};
   pmr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .warm_resetn(warm_resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_wakeup_pin(pin), .host_request_evt(evt[3]), .master_abort_evt(evt[2]),
      .target_abort_evt(evt[1]), .power_state_evt(evt[0]), .xfer_step(step),
      .local_word_addr(laddr), .local_step_hold(hold), .pci_word_addr(paddr), .irq(irq));
   pmr_far_model u_far (.aclk(aclk), .kick(kick), .evt(evt), .pin(pin), .step(step));
   always #5 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 0;
         if (wready)
            wvalid <= 0;
      end
      while (!bvalid);
      bready <= 0;
      bresp_got = bresp;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 0;
      end
      while (!rvalid);
      rready <= 0;
      rresp_got = rresp;
      chk(rdata, exp);
   endtask
   // one request to the far side, then enough cycles for the wakeup synchroniser
   task automatic fire(input int b);
      @(posedge aclk);
      kick <= 7'h1 << b;
      @(posedge aclk);
      kick <= 0;
      repeat (10) @(posedge aclk);
   endtask
   task automatic reset_reads;
      rchk(4'h0, 32'h8);
      rchk(4'h4, 32'h0);
      rchk(4'h8, 32'h0);
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_count++;
         end_sim;
      end
   end
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      reset_reads;
      foreach (rows[i])
      begin
         wr(rows[i][67:64], rows[i][63:32]);
         rchk(rows[i][67:64], rows[i][31:0]);
      end
      chk({paddr, 2'b0}, 32'ha5a5a5a4);
      chk({30'h0, bresp_got}, 32'h0);
      chk({30'h0, rresp_got}, 32'h0);
      // an unmapped offset answers with an error and leaves the registers alone
      wr(4'h2, 32'hffffffff);
      chk({30'h0, bresp_got}, 32'h2);
      rchk(4'h2, 32'h0);
      chk({30'h0, rresp_got}, 32'h2);
      rchk(4'h4, 32'h12345678);
      chk({hold, 1'b0}, 2'b00);
      for (int i = 0; i < 6; i++)
      begin
         wr(4'h0, 32'h1 << i);
         fire(i);
         chk({31'h0, irq}, 32'h1);
         rchk(4'hc, 32'h1 << i);
         repeat (3) @(posedge aclk);
         chk({31'h0, irq}, 32'h0);
      end
      wr(4'h0, 32'h0);
      fire(2);
      chk({31'h0, irq}, 32'h0);
      wr(4'h0, 32'h4);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      rchk(4'hc, 32'h4);
      wr(4'h4, 32'h12fffffc);
      fire(6);
      chk({laddr, 2'b0}, 32'h12000000);
      wr(4'h4, 32'h12000006);
      fire(6);
      rchk(4'h4, 32'h12000006);
      @(posedge aclk);
      warm_resetn <= 0;
      @(posedge aclk);
      warm_resetn <= 1;
      reset_reads;
      end_sim;
   end
endmodule
`default_nettype wire
